// File: core/flrw_pkg.sv
/*
 * Shared constants for the sector lock byte write link: command codes, frame
 * lengths, address and data field positions, host register map and timing.
 * Assumes a 100 MHz system clock on both ends of the link.
 */
package flrw_pkg;
	// ************************************************
	// Commands and frame lengths
	// ************************************************
	localparam logic [7:0] CMD_ARM_WRITE      = 8'h06;
	localparam logic [7:0] LOCK_BYTE_WRITE_CMD = 8'hE5;
	localparam logic [5:0] ARM_FRAME_BITS     = 6'h08;
	localparam logic [5:0] LOCK_FRAME_BITS    = 6'h28;
	localparam logic [5:0] FRAME_BITS_SAT     = 6'h29;

	// ************************************************
	// Address and data byte fields
	// ************************************************
	localparam int SECTOR_LSB  = 16;
	localparam int SUBSEC_LSB  = 12;
	localparam int BIT_SEC_WL  = 0;
	localparam int BIT_SEC_LD  = 1;
	localparam int BIT_SUB_WL  = 2;
	localparam int BIT_SUB_LD  = 3;
	localparam int BIT_SUB_SEL = 7;

	// ************************************************
	// Host register map and fields
	// ************************************************
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h4;
	localparam logic [3:0] REG_DATA   = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int CTRL_GO   = 0;
	localparam int CTRL_KIND = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;

	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_PERIOD_NS      = 10;
	localparam int MIN_DESELECT_TIME_NS = 100;
	localparam int MIN_DESELECT_CYC   =
		(MIN_DESELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_HALF_CYC      = 4;
endpackage

// File: core/flrw_link_if.sv
/*
 * Serial link between the lock byte host and the flash side.
 * Assumes both ends share one system clock; the device resynchronises anyway.
 */
`timescale 1ns/1ns
interface flrw_link_if;
	logic sel_n;          // Active-low select
	logic sclk;           // Serial clock from the host
	logic serial_in_line; // Serial data into the device

	modport dev  (input sel_n, input sclk, input serial_in_line);
	modport host (output sel_n, output sclk, output serial_in_line);
endinterface

// File: core/flrw_dev.sv
/*
 * Flash side of the lock byte write: decodes the arm command and the lock
 * byte write frame, keeps the volatile sector and subsector lock state, and
 * answers protection checks from the rest of the flash.
 * Assumes link pins are asynchronous to i_sys_clk and sclk is well below
 * a quarter of the system clock.
 */
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ns
// How it works
// [RULE_01] Lock write needs armed write latch
// [RULE_02] Host sends code, three address bytes, data
// [RULE_03] Address only selects the sector; edge sectors with b7 set also take the subsector from bits 15:12
// [RULE_04] Commit only on select rise after 40 bits
// [RULE_05] Clear write latch right after commit
// [RULE_06] Reject lock write during running cycle
// [RULE_07] Ordinary sectors: b1 freeze, b0 guard
// [RULE_08] Edge sectors top bit set: b3, b2
// [RULE_09] Edge sectors top bit clear: b1, b0
// [RULE_10] Sector freeze forces subsector freezes
// [RULE_11] Sector guard set forces subsector guards
// [RULE_12] Sector guard clear frees unfrozen subsectors
// [RULE_13] Guarded regions refuse modifying commands
// [RULE_14] Guard applied first, freeze second
// [RULE_15] Frozen bits stay until reset
module flrw_dev #(
	parameter int NSEC        = 16, // Sectors in the array
	parameter int NSUB        = 16, // Subsectors per sector
	parameter bit EDGE_SUBSEC = 1'b1 // Edge sectors carry subsector locks
) (
	input  wire logic         i_sys_clk,      // System clock
	input  wire logic         i_rst_n,        // Synchronous reset, active low
	flrw_link_if.dev          link,           // Serial link from host
	input  wire logic         i_cycle_busy,   // Program/erase/write running
	input  wire logic         i_arm_clear,    // Other command cleared the latch
	input  wire logic         i_mod_req,      // Modify request pulse
	input  wire logic         i_mod_bulk,     // Request is whole-array erase
	input  wire logic [23:0]  i_mod_addr,     // Address of modify request
	input  wire logic [23:0]  i_query_addr,   // Address to report locks for
	output logic              o_write_arm_latch, // Write latch state
	output logic              o_commit_ok,    // Lock write executed pulse
	output logic              o_commit_rej,   // Lock write rejected pulse
	output logic              o_mod_grant,    // Modify allowed pulse
	output logic              o_mod_refuse,   // Modify refused pulse
	output logic [7:0]        o_sector_lock_byte // Lock byte of query address
);
	import flrw_pkg::*;

	localparam int SW = $clog2(NSEC);
	localparam int BW = $clog2(NSUB);

	typedef struct packed {
		logic [2:0]                 s1;        // First sync stage
		logic [2:0]                 s2;        // Second sync stage
		logic                       sclk_prev;
		logic                       sel_prev;
		logic [39:0]                shift;
		logic [5:0]                 cnt;
		logic                       arm;
		logic [NSEC-1:0]            sec_wl;
		logic [NSEC-1:0]            sec_ld;
		logic [1:0][NSUB-1:0]       sub_wl;    // [0] first sector, [1] last
		logic [1:0][NSUB-1:0]       sub_ld;
		logic                       ok;
		logic                       rej;
		logic                       grant;
		logic                       refuse;
		logic [7:0]                 view;
	} flrw_dev_st_type;

	flrw_dev_st_type q, d;

	logic            sel_n, sclk, sdi;
	logic [23:0]     f_addr;
	logic [7:0]      f_data;
	logic [SW-1:0]   f_sec, m_sec, v_sec;
	logic [BW-1:0]   f_sub, m_sub, v_sub;
	logic            f_edge, m_edge, v_edge;
	logic            f_j, m_j, v_j;
	logic            any_guard, m_guard;

	// ************************************************
	// Field decode of the frame and the checks
	// ************************************************
	// Stage two only; stage one feeds nothing but stage two
	assign sel_n  = q.s2[2];
	assign sclk   = q.s2[1];
	assign sdi    = q.s2[0];
	assign f_addr = q.shift[31:8];
	assign f_data = q.shift[7:0];
	assign f_sec  = f_addr[SECTOR_LSB +: SW]; // RULE_03
	assign f_sub  = f_addr[SUBSEC_LSB +: BW];
	assign f_edge = EDGE_SUBSEC && (f_sec == '0 || f_sec == SW'(NSEC - 1));
	// Edge sectors share one pair of subsector arrays: index 0 is the first
	// sector, index 1 the last; the index means nothing elsewhere
	assign f_j    = (f_sec != '0);
	assign m_sec  = i_mod_addr[SECTOR_LSB +: SW];
	assign m_sub  = i_mod_addr[SUBSEC_LSB +: BW];
	assign m_edge = EDGE_SUBSEC && (m_sec == '0 || m_sec == SW'(NSEC - 1));
	assign m_j    = (m_sec != '0);
	assign v_sec  = i_query_addr[SECTOR_LSB +: SW];
	assign v_sub  = i_query_addr[SUBSEC_LSB +: BW];
	assign v_edge = EDGE_SUBSEC && (v_sec == '0 || v_sec == SW'(NSEC - 1));
	assign v_j    = (v_sec != '0);
	// Bulk erase is blocked by any guard anywhere
	assign any_guard = (|q.sec_wl) | (|q.sub_wl);
	assign m_guard   = i_mod_bulk ? any_guard :
		(q.sec_wl[m_sec] | (m_edge & q.sub_wl[m_j][m_sub]));

	// ************************************************
	// Next state
	// ************************************************
	always_comb begin
		d        = q;
		d.s1     = {link.sel_n, link.sclk, link.serial_in_line};
		d.s2     = q.s1;
		d.sclk_prev = sclk;
		d.sel_prev  = sel_n;
		d.ok     = 1'b0;
		d.rej    = 1'b0;
		d.grant  = 1'b0;
		d.refuse = 1'b0;
		// Other finished cycles drop the latch; an arm decoded further down
		// overrides this, so a set and a clear in one edge leave it set
		if (i_arm_clear) begin
			d.arm = 1'b0;
		end
		// Shift on sclk rising while selected, count saturates past a frame
		if (sel_n) begin
			d.cnt = '0;
		end else if (sclk && !q.sclk_prev) begin
			d.shift = {q.shift[38:0], sdi}; // RULE_02
			if (q.cnt != FRAME_BITS_SAT) begin
				d.cnt = q.cnt + 6'h01;
			end
		end
		// Select rise ends the frame; only an exact length counts
		if (sel_n && !q.sel_prev) begin
			if (q.cnt == ARM_FRAME_BITS && f_data == CMD_ARM_WRITE && !i_cycle_busy) begin
				d.arm = 1'b1;
			end else if (q.shift[39:32] == LOCK_BYTE_WRITE_CMD
				&& q.cnt >= ARM_FRAME_BITS + 6'h18) begin
				// A lock code of 32 or more bits but not exactly 40 is refused loudly, not dropped
				if (q.cnt != LOCK_FRAME_BITS || !q.arm || i_cycle_busy) begin // RULE_04
					d.rej = 1'b1; // RULE_01 RULE_06
				end else begin
					d.ok  = 1'b1;
					d.arm = 1'b0; // RULE_05
					if (f_edge && f_data[BIT_SUB_SEL]) begin
						// Only b3 and b2 touch the addressed subsector
						if (!q.sec_ld[f_sec] && !q.sub_ld[f_j][f_sub]) begin // RULE_15
							// A set sector guard still wins over a subsector clear
							d.sub_wl[f_j][f_sub] = f_data[BIT_SUB_WL] | q.sec_wl[f_sec]; // RULE_11
							d.sub_ld[f_j][f_sub] = f_data[BIT_SUB_LD]; // RULE_08
						end
					end else if (!q.sec_ld[f_sec]) begin // RULE_15
						// Guard first with its subsector effects, freeze second
						d.sec_wl[f_sec] = f_data[BIT_SEC_WL]; // RULE_07 RULE_09 RULE_14
						if (f_edge) begin
							d.sub_wl[f_j] = f_data[BIT_SEC_WL] ? '1 : // RULE_11
								(q.sub_wl[f_j] & q.sub_ld[f_j]); // RULE_12
						end
						d.sec_ld[f_sec] = f_data[BIT_SEC_LD]; // RULE_07 RULE_09 RULE_14
						if (f_edge && f_data[BIT_SEC_LD]) begin
							d.sub_ld[f_j] = '1; // RULE_10
						end
					end
				end
			end
		end
		// Protection check for program and erase requests; the answer is
		// registered, so it lands one cycle after the request pulse
		if (i_mod_req) begin
			d.grant  = !m_guard; // RULE_13
			d.refuse = m_guard; // RULE_13
		end
		// Report view; subsector bits read zero outside edge sectors
		d.view = {4'h0,
			v_edge & q.sub_ld[v_j][v_sub], v_edge & q.sub_wl[v_j][v_sub],
			q.sec_ld[v_sec], q.sec_wl[v_sec]};
	end

	// ************************************************
	// State register
	// ************************************************
	// Reset idles the synchronised select and sclk high so no false edge follows release.
	// Lock bits are volatile: this reset is the only way to unfreeze them.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			q           <= '0;
			q.s1        <= 3'h6;
			q.s2        <= 3'h6;
			q.sel_prev  <= 1'b1;
			q.sclk_prev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	// Every output is a register copy, so no decode glitch reaches a pin
	assign o_write_arm_latch  = q.arm;
	assign o_commit_ok        = q.ok;
	assign o_commit_rej       = q.rej;
	assign o_mod_grant        = q.grant;
	assign o_mod_refuse       = q.refuse;
	assign o_sector_lock_byte = q.view;
endmodule

// File: core/flrw_host.sv
/*
 * Host end of the lock byte write link: a register-driven serial master that
 * sends either the arm command or a full lock byte write frame, mode 0.
 * Assumes software writes ADDR and DATA before setting GO in CTRL.
 */
`timescale 1ns/1ns
module flrw_host #(
	parameter int HALF_CYC = flrw_pkg::SCLK_HALF_CYC, // Cycles per sclk half
	parameter int DESEL_CYC = flrw_pkg::MIN_DESELECT_CYC // Select high time
) (
	input  wire logic         i_sys_clk, // System clock
	input  wire logic         i_rst_n,   // Synchronous reset, active low
	input  wire logic [3:0]   i_addr,    // Register byte address
	input  wire logic [31:0]  i_wdata,   // Write data
	input  wire logic         i_wr,      // Write strobe
	input  wire logic         i_rd,      // Read strobe
	output logic [31:0]       o_rdata,   // Read data, cycle after i_rd
	flrw_link_if.host         link       // Serial link to the device
);
	import flrw_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DESEL} flrw_host_state_type;

	typedef struct packed {
		flrw_host_state_type state;
		logic [7:0]          tick;
		logic [5:0]          left;
		logic [39:0]         shift;
		logic                sclk;
		logic                sel_n;
		logic                kind;
		logic [23:0]         addr;
		logic [7:0]          data;
		logic                done;
		logic [31:0]         rdata;
	} flrw_host_st_type;

	flrw_host_st_type q, d;

	// ************************************************
	// Next state
	// ************************************************
	always_comb begin
		d       = q;
		d.rdata = 32'h0;
		// Register writes; GO is ignored while a frame is running
		if (i_wr) begin
			case (i_addr)
				REG_ADDR: d.addr = i_wdata[23:0];
				REG_DATA: d.data = i_wdata[7:0];
				REG_CTRL: begin
					if (q.state == ST_IDLE && i_wdata[CTRL_GO]) begin
						d.kind  = i_wdata[CTRL_KIND];
						d.done  = 1'b0;
						d.state = ST_SHIFT;
						d.sel_n = 1'b0;
						d.tick  = '0;
						// RULE_01 RULE_02 KIND set sends code, address, data; KIND clear sends the arm command alone
						d.shift = i_wdata[CTRL_KIND] ?
							{LOCK_BYTE_WRITE_CMD, q.addr, q.data} :
							{CMD_ARM_WRITE, 32'h0};
						d.left  = i_wdata[CTRL_KIND] ? LOCK_FRAME_BITS : ARM_FRAME_BITS;
					end
				end
				default: ;
			endcase
		end
		// Reads answer one cycle later; unmapped reads give zero
		if (i_rd) begin
			case (i_addr)
				REG_CTRL:   d.rdata = {30'h0, q.kind, 1'b0};
				REG_ADDR:   d.rdata = {8'h0, q.addr};
				REG_DATA:   d.rdata = {24'h0, q.data};
				REG_STATUS: d.rdata = {30'h0, q.done, q.state != ST_IDLE};
				default:    d.rdata = 32'h0;
			endcase
		end
		// Serial sequencer: data set while sclk low, device samples on rise
		case (q.state)
			ST_IDLE: ;
			ST_SHIFT: begin
				d.tick = q.tick + 8'h01;
				if (q.tick == 8'(HALF_CYC - 1)) begin
					d.tick = '0;
					if (!q.sclk) begin
						d.sclk = 1'b1;
					end else begin
						d.sclk  = 1'b0;
						d.shift = {q.shift[38:0], 1'b0};
						d.left  = q.left - 6'h01;
						if (q.left == 6'h01) begin
							d.sel_n = 1'b1; // RULE_04
							d.state = ST_DESEL;
						end
					end
				end
			end
			ST_DESEL: begin
				// Keep select high long enough between frames
				d.tick = q.tick + 8'h01;
				if (q.tick == 8'(DESEL_CYC - 1)) begin
					d.tick  = '0;
					d.done  = 1'b1;
					d.state = ST_IDLE;
				end
			end
			default: d.state = ST_IDLE;
		endcase
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			q       <= '0;
			q.state <= ST_IDLE;
			q.sel_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign o_rdata             = q.rdata;
	assign link.sel_n          = q.sel_n;
	assign link.sclk           = q.sclk;
	assign link.serial_in_line = q.shift[39];
endmodule

// File: tb/flrw_monitor.sv
/*
 * Checker for the lock byte link: serial pins and device outputs.
 * Assumes one clock and the synchronous reset shared by both ends.
 */
`timescale 1ns/1ns
module flrw_monitor (
	input wire logic        i_sys_clk,          // System clock
	input wire logic        i_rst_n,            // Reset, active low
	input wire logic        i_sel_n,            // Link select, active low
	input wire logic        i_sclk,             // Link clock
	input wire logic        i_serial_in_line,   // Link data
	input wire logic        i_write_arm_latch,  // Write latch
	input wire logic        i_commit_ok,        // Executed pulse
	input wire logic        i_commit_rej,       // Rejected pulse
	input wire logic        i_cycle_busy,       // Running cycle
	input wire logic        i_mod_req,          // Modify request
	input wire logic        i_mod_grant,        // Modify allowed
	input wire logic        i_mod_refuse,       // Modify refused
	input wire logic [23:0] i_query_addr,       // Query address
	input wire logic [7:0]  i_sector_lock_byte  // Query lock byte
);
	import flrw_pkg::*;
	logic [23:0] q1_q;
	logic [23:0] q2_q;
	logic        hold_edge;

	// Query history; the lock byte lags a query change by a cycle
	always_ff @(posedge i_sys_clk) begin
		q1_q <= i_query_addr;
		q2_q <= q1_q;
	end
	assign hold_edge = (q1_q == i_query_addr) && (q2_q == q1_q)
		&& (i_query_addr[19:16] == 4'h0 || i_query_addr[19:16] == 4'hF);

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	// ************************************************
	// Link framing and commit
	// ************************************************
	a_sclk_idle_low: assert property (i_sel_n |-> !i_sclk)
		else $error("sclk high while deselected");
	// Data may only move while sclk is low, so the rise sees a settled bit
	a_data_steady: assert property (i_sclk |-> $stable(i_serial_in_line))
		else $error("link data moved while sclk high");
	// Pulse lands three edges after the pin rise: two sync stages, then the registered edge decode
	a_commit_on_rise: assert property ((i_commit_ok || i_commit_rej) |->
		i_sel_n && $past(i_sel_n, 3) && !$past(i_sel_n, 4))
		else $error("commit without select rise");
	a_ok_needs_arm: assert property (i_commit_ok |-> $past(i_write_arm_latch))
		else $error("commit without armed latch");
	a_latch_clears: assert property (i_commit_ok |-> ##[1:2] !i_write_arm_latch)
		else $error("latch not cleared after commit");
	// The decision was taken one edge before the pulse shows
	a_busy_rejects: assert property (i_commit_ok |-> !$past(i_cycle_busy))
		else $error("commit during running cycle");

	// ************************************************
	// Lock state and protection
	// ************************************************
	a_mod_answers: assert property (i_mod_req |=> i_mod_grant != i_mod_refuse)
		else $error("modify check gave no single answer");
	a_upper_zero: assert property (i_sector_lock_byte[7:4] == 4'h0)
		else $error("lock byte upper bits set");
	a_guard_forced: assert property (hold_edge && i_sector_lock_byte[0] |-> i_sector_lock_byte[2])
		else $error("subsector guard not forced");
	a_freeze_forced: assert property (hold_edge && i_sector_lock_byte[1] |-> i_sector_lock_byte[3])
		else $error("subsector freeze not forced");
endmodule

// File: tb/flash_lock_register_write_tb.sv
/*
 * Self-checking bench: host and device joined by the link interface.
 * Assumes the host register map and clock period of the shared package; host sclk halves and deselect are set here to 3 and 2 cycles.
 */
`timescale 1ns/1ns
module flash_lock_register_write_tb;
	import flrw_pkg::*;
	localparam logic [1:0] OK = 2'b01;
	localparam logic [1:0] RJ = 2'b10;
	logic        i_sys_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        wr = 1'b0, rd = 1'b0, rd_chk = 1'b0, rd_d = 1'b0, smp = 1'b0;
	logic        busy = 1'b0, aclr = 1'b0, mreq = 1'b0, mbulk = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [23:0] maddr = 24'h0, qaddr = 24'h0;
	logic [31:0] rdata;
	logic        latch, c_ok, c_rej, m_gr, m_rf;
	logic [7:0]  lbyte;
	logic [35:0] notes[$];
	int          err_total = 0;
	int          checks = 0;

	always #5 i_sys_clk = ~i_sys_clk;

	flrw_link_if i_flrw_link_if ();
	flrw_host #(.HALF_CYC(3), .DESEL_CYC(2)) i_flrw_host (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .link(i_flrw_link_if));
	flrw_dev i_flrw_dev (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .link(i_flrw_link_if),
		.i_cycle_busy(busy), .i_arm_clear(aclr), .i_mod_req(mreq), .i_mod_bulk(mbulk),
		.i_mod_addr(maddr), .i_query_addr(qaddr), .o_write_arm_latch(latch),
		.o_commit_ok(c_ok), .o_commit_rej(c_rej), .o_mod_grant(m_gr),
		.o_mod_refuse(m_rf), .o_sector_lock_byte(lbyte));
	flrw_monitor i_flrw_monitor (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_sel_n(i_flrw_link_if.sel_n), .i_sclk(i_flrw_link_if.sclk),
		.i_serial_in_line(i_flrw_link_if.serial_in_line), .i_write_arm_latch(latch),
		.i_commit_ok(c_ok), .i_commit_rej(c_rej), .i_cycle_busy(busy), .i_mod_req(mreq),
		.i_mod_grant(m_gr), .i_mod_refuse(m_rf), .i_query_addr(qaddr),
		.i_sector_lock_byte(lbyte));

	// ************************************************
	// Result side: oldest note against each result
	// ************************************************
	task results();
		if (err_total == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task take(input logic [35:0] g);
		logic [35:0] e;
		e = (notes.size() > 0) ? notes.pop_front() : '1;
		checks++;
		if (g !== e) begin
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
			err_total++;
		end
	endtask

	// Results sampled before the edge's own updates land
	always @(posedge i_sys_clk) begin
		rd_d <= rd && rd_chk;
		if (rd_d) take({4'h0, rdata});
		if (c_ok || c_rej) take({4'h1, 30'h0, c_rej, c_ok});
		if (m_gr || m_rf) take({4'h2, 30'h0, m_rf, m_gr});
		if (smp) take({4'h3, 23'h0, latch, lbyte});
	end

	// ************************************************
	// Driver tasks
	// ************************************************
	task wreg(input logic [3:0] a, input logic [31:0] d);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge i_sys_clk);
		wr <= 1'b0;
		#1;
	endtask

	task rreg(input logic [3:0] a, input logic chk, input logic [31:0] e);
		if (chk) notes.push_back({4'h0, e});
		addr <= a; rd <= 1'b1; rd_chk <= chk;
		@(posedge i_sys_clk);
		rd <= 1'b0;
		#1;
	endtask

	// Done is polled with a bound; a hang ends the run
	task frame(input logic k, input logic [23:0] a, input logic [7:0] d);
		int n;
		wreg(REG_ADDR, {8'h00, a});
		wreg(REG_DATA, {24'h0, d});
		wreg(REG_CTRL, {30'h0, k, 1'b1});
		for (n = 0; n < 3000; n++) begin
			rreg(REG_STATUS, 1'b0, 32'h0);
			if (rdata[STAT_DONE] === 1'b1) break;
		end
		if (n == 3000) begin
			err_total++;
			results();
		end
		repeat (6) @(posedge i_sys_clk);
		#1;
	endtask

	task arm();
		frame(1'b0, 24'h0, 8'h00);
	endtask

	task lock(input logic [23:0] a, input logic [7:0] d, input logic [1:0] e);
		notes.push_back({4'h1, 30'h0, e});
		frame(1'b1, a, d);
	endtask

	task look(input logic [23:0] a, input logic [8:0] e);
		notes.push_back({4'h3, 23'h0, e});
		qaddr <= a;
		repeat (3) @(posedge i_sys_clk);
		smp <= 1'b1;
		@(posedge i_sys_clk);
		smp <= 1'b0;
		#1;
	endtask

	task modq(input logic [23:0] a, input logic b, input logic [1:0] e);
		notes.push_back({4'h2, 30'h0, e});
		maddr <= a; mbulk <= b; mreq <= 1'b1;
		@(posedge i_sys_clk);
		mreq <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		#1;
	endtask

	// Random offset inside a sector, so any address must pick it
	function automatic logic [23:0] ra(input logic [3:0] s);
		return {4'h0, s, 16'($urandom)};
	endfunction

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		void'($urandom(4));
		repeat (8) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		#1;
		lock(ra(4'h5), 8'h03, RJ);
		arm();
		look(ra(4'h5), 9'h100);
		lock(ra(4'h5), 8'h03, OK);
		look(ra(4'h5), 9'h003);
		rreg(REG_STATUS, 1'b1, 32'h2);
		rreg(4'h2, 1'b1, 32'h0);
		arm();
		aclr <= 1'b1;
		@(posedge i_sys_clk);
		aclr <= 1'b0;
		#1;
		lock(ra(4'h0), 8'h01, RJ);
		arm();
		busy <= 1'b1;
		lock(ra(4'h0), 8'h01, RJ);
		busy <= 1'b0;
		lock(ra(4'h0), 8'h01, OK);
		look(ra(4'h0), 9'h005);
		modq(ra(4'h0), 1'b0, RJ);
		modq(ra(4'h3), 1'b1, RJ);
		modq(ra(4'h3), 1'b0, OK);
		arm();
		lock(ra(4'h0), 8'h02, OK);
		look(ra(4'h0), 9'h00A);
		modq(ra(4'h0), 1'b0, OK);
		arm();
		lock(ra(4'h0), 8'h01, OK);
		look(ra(4'h0), 9'h00A);
		arm();
		lock({8'h0F, 4'h3, 12'($urandom)}, 8'h84, OK);
		look({8'h0F, 4'h3, 12'($urandom)}, 9'h004);
		look({8'h0F, 4'h4, 12'($urandom)}, 9'h000);
		arm();
		lock(ra(4'hF), 8'h01, OK);
		look({8'h0F, 4'h4, 12'($urandom)}, 9'h005);
		arm();
		lock({8'h0F, 4'h4, 12'($urandom)}, 8'h80, OK);
		look({8'h0F, 4'h4, 12'($urandom)}, 9'h005);
		// Second reset: frozen bits are volatile and must come back clear
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		#1;
		look(ra(4'h0), 9'h000);
		if (notes.size() != 0) err_total++;
		results();
	end
endmodule
